// [core/afs_regmem.sv]
/*
  Byte-wide register store with registered read data.
  Assumes the core keeps writes inside the writable range.
*/
`timescale 1ns/1ps
module afs_regmem #(
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr_n,
  afs_mem_if.mem mif
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] cells;
    logic [7:0] rdata;
  } afs_mem_t;
  afs_mem_t s_ff, nxt_s;

  // Write, registered read, clear to defaults
  always_comb begin
    nxt_s = s_ff;
    if (mif.we) begin
      nxt_s.cells[mif.waddr] = mif.wdata;
    end
    nxt_s.rdata = s_ff.cells[mif.raddr];
    if (!clr_n) begin
      nxt_s = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign mif.rdata = s_ff.rdata;
endmodule

// [core/afs_spi_port.sv]
/*
  Serial register port of a two-channel converter front end: command
  decode, address counter with read loops and write increment, channel
  data latches, data-ready pulse and hardware reset handling.
  Assumes all serial pins and the reset pin are asynchronous to ref_clk,
  and channel data with its strobe arrives on ref_clk.
*/
`timescale 1ns/1ps
`include "afs_regs.svh"
module afs_spi_port #(
  parameter logic [1:0] CHIP_ADDR = `AFS_CHIP_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hw_reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic conv_ready_pulse_n,
  output logic conv_ready_pulse_n_oe,
  input wire logic [23:0] ch0_data,
  input wire logic [23:0] ch1_data,
  input wire logic ch_data_new,
  output afs_pkg::afs_state_t link_state
);
  import afs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam afs_core_t CORE_RST = '{
    st: AFS_ST_IDLE,
    stat: `AFS_STAT_RST,
    dr_n: 1'b1,
    default: '0
  };

  afs_core_t s_ff, nxt_s;
  logic rst_n_meta_ff;
  logic rst_n_sync_ff;
  logic [3:0] pins_s;
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic hw_s;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic byte_done;
  logic wr_done;
  logic rd_load;
  logic inc_on;
  logic w0_16;
  logic w1_16;
  afs_loop_t loop_sel;

  afs_mem_if mif ();

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  // Reset released through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_n_meta_ff <= 1'b0;
      rst_n_sync_ff <= 1'b0;
    end else begin
      rst_n_meta_ff <= 1'b1;
      rst_n_sync_ff <= rst_n_meta_ff;
    end
  end

  afs_sync #(
    .W(4),
    .RST(`AFS_SYNC_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n_sync_ff),
    .d({spi_cs_n, spi_sck, spi_sdi, hw_reset_n}),
    .q(pins_s)
  );

  assign cs_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign hw_s = pins_s[0];

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  afs_regmem #(
    .DEPTH(32)
  ) u_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n_sync_ff),
    .clr_n(hw_s),
    .mif(mif)
  );

  assign mif.we = s_ff.we;
  assign mif.waddr = s_ff.waddr;
  assign mif.wdata = s_ff.wdata;
  assign mif.raddr = s_ff.addr;

  // ----------------------------------------------------------------
  // Read address sequencing
  // ----------------------------------------------------------------
  // Next read address for the loop mode, skipping 16-bit low bytes
  function automatic logic [4:0] next_rd(
    input logic [4:0] a,
    input afs_loop_t lp,
    input logic n0,
    input logic n1
  );
    logic [4:0] lo;
    logic [4:0] hi;
    logic [4:0] nx;
    nx = 5'(a + 5'h01);
    if (n0 && nx == `AFS_A_CH0_LSB) begin
      nx = `AFS_A_CH1_MSB;
    end
    if (n1 && nx == `AFS_A_CH1_LSB) begin
      nx = `AFS_A_WR_FIRST;
    end
    lo = `AFS_A_CH0_MSB;
    hi = `AFS_A_LAST;
    case (lp)
      AFS_LP_SAME: begin
        lo = a;
        hi = a;
      end
      AFS_LP_GROUP: begin
        if (a <= `AFS_A_CH0_LSB) begin
          lo = `AFS_A_CH0_MSB;
          hi = `AFS_A_CH0_LSB;
        end else if (a <= `AFS_A_CH1_LSB) begin
          lo = `AFS_A_CH1_MSB;
          hi = `AFS_A_CH1_LSB;
        end else if (a <= `AFS_A_G2_END) begin
          lo = `AFS_A_WR_FIRST;
          hi = `AFS_A_G2_END;
        end else if (a <= `AFS_A_G3_END) begin
          lo = `AFS_A_G3_FIRST;
          hi = `AFS_A_G3_END;
        end else if (a <= `AFS_A_G4_END) begin
          lo = `AFS_A_G4_FIRST;
          hi = `AFS_A_G4_END;
        end else if (a <= `AFS_A_G5_END) begin
          lo = `AFS_A_G5_FIRST;
          hi = `AFS_A_G5_END;
        end else begin
          lo = `AFS_A_LAST;
          hi = `AFS_A_LAST;
        end
      end
      AFS_LP_TYPE: begin
        if (a < `AFS_A_WR_FIRST) begin
          lo = `AFS_A_CH0_MSB;
          hi = `AFS_A_CH1_LSB;
        end else begin
          lo = `AFS_A_WR_FIRST;
          hi = `AFS_A_LAST;
        end
      end
      default: begin
        lo = `AFS_A_CH0_MSB;
        hi = `AFS_A_LAST;
      end
    endcase
    return (nx > hi) ? lo : nx;
  endfunction

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  // Edges of the sampled serial clock
  assign sck_rise = sck_s && !s_ff.sck_q;
  assign sck_fall = !sck_s && s_ff.sck_q;

  // Incoming byte, MSB first
  assign rx_byte = {s_ff.rx_sr[6:0], sdi_s};
  assign byte_done = sck_rise && s_ff.bitcnt == `AFS_BIT_LAST;
  assign wr_done = s_ff.st == AFS_ST_WR && byte_done && !cs_s && hw_s;
  assign rd_load = s_ff.st == AFS_ST_RD && sck_fall && s_ff.bitcnt == 3'h0;

  // Loop, increment and width settings
  assign loop_sel = afs_loop_t'(s_ff.stat[`AFS_STAT_RD_HI:`AFS_STAT_RD_LO]);
  assign inc_on = s_ff.stat[`AFS_STAT_WR_INC];
  assign w1_16 = s_ff.stat[`AFS_STAT_WID_HI:`AFS_STAT_WID_LO] != `AFS_WID_BOTH24;
  assign w0_16 = s_ff.stat[`AFS_STAT_WID_HI:`AFS_STAT_WID_LO] == `AFS_WID_BOTH16;

  // Byte presented for the current read address
  always_comb begin
    case (s_ff.addr)
      `AFS_A_CH0_MSB: rd_byte = s_ff.ch0[23:16];
      `AFS_A_CH0_MID: rd_byte = s_ff.ch0[15:8];
      `AFS_A_CH0_LSB: rd_byte = s_ff.ch0[7:0];
      `AFS_A_CH1_MSB: rd_byte = s_ff.ch1[23:16];
      `AFS_A_CH1_MID: rd_byte = s_ff.ch1[15:8];
      `AFS_A_CH1_LSB: rd_byte = s_ff.ch1[7:0];
      `AFS_A_STAT: rd_byte = s_ff.stat;
      default: rd_byte = mif.rdata;
    endcase
    if (s_ff.undef) begin
      rd_byte = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Transaction engine
  // ----------------------------------------------------------------
  // Next state of the whole core
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sck_q = sck_s;
    nxt_s.we = 1'b0;
    nxt_s.dr_n = !ch_data_new;
    if (ch_data_new) begin
      nxt_s.ch0 = ch0_data;
      nxt_s.ch1 = ch1_data;
    end
    case (s_ff.st)
      AFS_ST_IDLE: begin
        if (!cs_s) begin
          nxt_s.st = AFS_ST_CMD;
          nxt_s.bitcnt = 3'h0;
        end
      end
      AFS_ST_CMD: begin
        // A leading falling edge is simply not counted
        if (sck_rise) begin
          nxt_s.rx_sr = rx_byte;
          nxt_s.bitcnt = 3'(s_ff.bitcnt + 3'h1);
          if (byte_done) begin
            nxt_s.addr = rx_byte[`AFS_CMD_REG_HI:`AFS_CMD_REG_LO];
            nxt_s.undef = rx_byte[`AFS_CMD_REG_HI:`AFS_CMD_REG_LO] > `AFS_A_LAST;
            if (rx_byte[`AFS_CMD_CHIP_HI:`AFS_CMD_CHIP_LO] != CHIP_ADDR) begin
              nxt_s.st = AFS_ST_SKIP;
            end else if (rx_byte[`AFS_CMD_RW]) begin
              nxt_s.st = AFS_ST_RD;
            end else begin
              nxt_s.st = AFS_ST_WR;
            end
          end
        end
      end
      AFS_ST_RD: begin
        if (sck_rise) begin
          nxt_s.bitcnt = 3'(s_ff.bitcnt + 3'h1);
          if (byte_done) begin
            nxt_s.addr = next_rd(s_ff.addr, loop_sel, w0_16, w1_16);
          end
        end
        // Output shifts on falling edges, new byte at bit zero
        if (rd_load) begin
          nxt_s.tx_sr = rd_byte;
        end else if (sck_fall) begin
          nxt_s.tx_sr = {s_ff.tx_sr[6:0], 1'b0};
        end
      end
      AFS_ST_WR: begin
        if (sck_rise) begin
          nxt_s.rx_sr = rx_byte;
          nxt_s.bitcnt = 3'(s_ff.bitcnt + 3'h1);
        end
        if (byte_done && !s_ff.undef) begin
          nxt_s.we = s_ff.addr >= `AFS_A_WR_FIRST;
          nxt_s.waddr = s_ff.addr;
          nxt_s.wdata = rx_byte;
          if (s_ff.addr == `AFS_A_STAT) begin
            nxt_s.stat = rx_byte;
          end
          if (inc_on && s_ff.addr == `AFS_A_LAST) begin
            nxt_s.addr = `AFS_A_WR_FIRST;
          end else if (inc_on) begin
            nxt_s.addr = 5'(s_ff.addr + 5'h01);
          end
        end
      end
      AFS_ST_SKIP: begin
        nxt_s.st = AFS_ST_SKIP;
      end
      default: begin
        nxt_s = CORE_RST;
      end
    endcase
    // Chip select high ends any transaction
    if (cs_s) begin
      nxt_s.st = AFS_ST_IDLE;
      nxt_s.bitcnt = 3'h0;
      nxt_s.undef = 1'b0;
    end
    // Reset pin restores every default
    if (!hw_s) begin
      nxt_s = CORE_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync_ff) begin
    if (!rst_n_sync_ff) begin
      s_ff <= CORE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data out driven only while reading a selected device
  assign spi_sdo = s_ff.tx_sr[7];
  assign spi_sdo_oe = s_ff.st == AFS_ST_RD && !cs_s && hw_s;
  assign conv_ready_pulse_n = s_ff.dr_n;
  assign conv_ready_pulse_n_oe = hw_s && (!s_ff.dr_n || s_ff.stat[`AFS_STAT_DR_DRIVE]);
  assign link_state = s_ff.st;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_sync_ff);

  property p_cs_release;
    cs_s |-> !spi_sdo_oe;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("sdo driven with cs high");

  property p_wr_release;
    s_ff.st == AFS_ST_WR |-> !spi_sdo_oe;
  endproperty
  a_wr_release: assert property (p_wr_release) else $error("sdo driven in write");

  property p_hw_release;
    !hw_s |=> s_ff.st == AFS_ST_IDLE && !s_ff.we && s_ff.stat == `AFS_STAT_RST;
  endproperty
  a_hw_release: assert property (p_hw_release) else $error("reset pin not obeyed");

  property p_hw_pins;
    !hw_s |-> !spi_sdo_oe && !conv_ready_pulse_n_oe;
  endproperty
  a_hw_pins: assert property (p_hw_pins) else $error("outputs driven in reset");

  property p_dr_pulse;
    ch_data_new && hw_s ##1 hw_s |-> !conv_ready_pulse_n && conv_ready_pulse_n_oe;
  endproperty
  a_dr_pulse: assert property (p_dr_pulse) else $error("no ready pulse");

  property p_dr_width;
    !conv_ready_pulse_n && !ch_data_new |=> conv_ready_pulse_n;
  endproperty
  a_dr_width: assert property (p_dr_width) else $error("ready pulse too long");

  property p_undef_wr;
    wr_done && s_ff.undef |=> !s_ff.we && s_ff.addr == $past(s_ff.addr);
  endproperty
  a_undef_wr: assert property (p_undef_wr) else $error("undefined write acted");

  property p_no_inc;
    wr_done && !inc_on |=> s_ff.addr == $past(s_ff.addr);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("address moved");

  property p_wrap;
    wr_done && inc_on && !s_ff.undef && s_ff.addr == `AFS_A_LAST
      |=> s_ff.addr == `AFS_A_WR_FIRST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("write wrap wrong");

  property p_ro_safe;
    s_ff.we |-> s_ff.waddr >= `AFS_A_WR_FIRST && s_ff.waddr <= `AFS_A_LAST;
  endproperty
  a_ro_safe: assert property (p_ro_safe) else $error("read-only written");

  property p_mismatch;
    s_ff.st == AFS_ST_CMD && byte_done && !cs_s && hw_s
      && rx_byte[`AFS_CMD_CHIP_HI:`AFS_CMD_CHIP_LO] != CHIP_ADDR
      |=> s_ff.st == AFS_ST_SKIP ##1 !spi_sdo_oe;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign chip answered");

  property p_undef_rd;
    rd_load && s_ff.undef && !cs_s && hw_s |=> s_ff.tx_sr == 8'h00;
  endproperty
  a_undef_rd: assert property (p_undef_rd) else $error("undefined read not zero");

  property p_tx_on_fall;
    hw_s && $past(hw_s) && s_ff.tx_sr != $past(s_ff.tx_sr) |-> $past(sck_fall);
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall) else $error("sdo moved off fall");

  property p_cs_ends;
    cs_s && s_ff.st != AFS_ST_IDLE && hw_s |=> s_ff.st == AFS_ST_IDLE;
  endproperty
  a_cs_ends: assert property (p_cs_ends) else $error("cs did not end frame");
endmodule

// [core/afs_sync.sv]
/*
  Two-flop synchroniser for pins from outside the clock domain.
  Assumes a synchronised active-low reset.
*/
`timescale 1ns/1ps
module afs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } afs_sync_t;
  afs_sync_t s_ff, nxt_s;

  // First stage feeds only the second
  always_comb begin
    nxt_s.meta = d;
    nxt_s.sync = s_ff.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{meta: RST, sync: RST};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.sync;
endmodule

// [include/afs_mem_if.sv]
/*
  Write and read port between the port core and its register store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface afs_mem_if;
  logic we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [include/afs_pkg.sv]
/*
  Types of the serial register port: states, loop modes, core state.
  Assumes afs_regs.svh on the include path.
*/
package afs_pkg;
  // Transaction states, one-hot
  typedef enum logic [4:0] {
    AFS_ST_IDLE = 5'h01,
    AFS_ST_CMD = 5'h02,
    AFS_ST_RD = 5'h04,
    AFS_ST_WR = 5'h08,
    AFS_ST_SKIP = 5'h10
  } afs_state_t;
  // Read address loop modes
  typedef enum logic [1:0] {
    AFS_LP_SAME = 2'h0,
    AFS_LP_GROUP = 2'h1,
    AFS_LP_TYPE = 2'h2,
    AFS_LP_MAP = 2'h3
  } afs_loop_t;
  // Whole state of the port core
  typedef struct packed {
    afs_state_t st;
    logic [2:0] bitcnt;
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    logic [4:0] addr;
    logic undef;
    logic [7:0] stat;
    logic [23:0] ch0;
    logic [23:0] ch1;
    logic sck_q;
    logic dr_n;
    logic we;
    logic [4:0] waddr;
    logic [7:0] wdata;
  } afs_core_t;
endpackage

// [include/afs_regs.svh]
/*
  Constants of the serial register port: register addresses, command and
  status field positions, reset values and bit counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH
// Summary of operation
// - Sample data in on rising clock edges, drive data out on falling edges.
// - A transaction spans chip select low; nothing carries into the next one.
// - Chip select high: data out released, clock and data in ignored; a write byte ending in the first cs-high sample is still stored.
// - First byte is the command byte; every later byte is data.
// - Command holds chip address, register address and direction bit.
// - Only a matching chip address responds; default chip address is 00.
// - Read of an undefined address returns zeros on every byte.
// - Write to an undefined address changes nothing, address stays.
// - First read byte from commanded address; later ones per loop field.
// - Write auto-increment steps address, wrapping from map end to 0x06.
// - Without auto-increment every written byte goes to one address.
// - Writes to read-only registers leave them unchanged.
// - Data out stays released during a write transaction.
// - Channel result is 16 or 24 bits per width setting.
// - With clock idling high, a leading falling edge is accepted.
// - Data-ready output pulses when new channel data arrives.
// - Hardware reset pin returns every register to its default.
// - Loop field: same address, group, type, or whole map.
// - A 16-bit channel's low byte is skipped in sequential reads.
// - Hardware reset low: writes ignored, serial and ready outputs released.

// Command byte and bit counting
`define AFS_CHIP_DEFAULT 2'h0
`define AFS_BIT_LAST 3'h7
`define AFS_CMD_RW 0
`define AFS_CMD_CHIP_HI 7
`define AFS_CMD_CHIP_LO 6
`define AFS_CMD_REG_HI 5
`define AFS_CMD_REG_LO 1

// Register map addresses
`define AFS_A_CH0_MSB 5'h00
`define AFS_A_CH0_MID 5'h01
`define AFS_A_CH0_LSB 5'h02
`define AFS_A_CH1_MSB 5'h03
`define AFS_A_CH1_MID 5'h04
`define AFS_A_CH1_LSB 5'h05
`define AFS_A_WR_FIRST 5'h06
`define AFS_A_G2_END 5'h09
`define AFS_A_G3_FIRST 5'h0a
`define AFS_A_G3_END 5'h0d
`define AFS_A_G4_FIRST 5'h0e
`define AFS_A_G4_END 5'h13
`define AFS_A_G5_FIRST 5'h14
`define AFS_A_G5_END 5'h19
`define AFS_A_LAST 5'h1a
`define AFS_A_STAT 5'h0c

// Communication status register fields and reset value
`define AFS_STAT_RST 8'hb8
`define AFS_STAT_RD_HI 7
`define AFS_STAT_RD_LO 6
`define AFS_STAT_WR_INC 5
`define AFS_STAT_WID_HI 4
`define AFS_STAT_WID_LO 3
`define AFS_STAT_DR_DRIVE 2
`define AFS_WID_BOTH24 2'h3
`define AFS_WID_BOTH16 2'h0

// Synchroniser reset: cs high, sck low, sdi low, reset pin high
`define AFS_SYNC_RST 4'h9
`endif

// [verification/afs_host_model.sv]
/*
  Behavioural serial host driving the register port: chip select, clock, data.
  Assumes the bench calls frame() once at a time and waits for it to return.
*/
`timescale 1ns/1ps
module afs_host_model (
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  // ----------------------------------------------------------------
  // Line model and frame task
  // ----------------------------------------------------------------
  logic last_sdo;
  logic sdo_line;
  logic oe_seen;

  // Released data line shows the inverse of its last driven level
  assign sdo_line = spi_sdo_oe ? spi_sdo : ~last_sdo;
  always @(spi_sdo or spi_sdo_oe) begin
    if (spi_sdo_oe) begin
      last_sdo = spi_sdo;
    end
  end

  // Idle pins at time zero
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    last_sdo = 1'b0;
    oe_seen = 1'b0;
  end

  // One whole frame, 800 ns clock, bytes taken from the top of tx
  task automatic frame(input logic mode11, input int nbytes, input logic [63:0] tx,
                       output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    spi_sck = mode11;
    #413;
    spi_cs_n = 1'b0;
    #400;
    for (int i = 0; i < 8 * nbytes; i++) begin
      spi_sck = 1'b0;
      spi_sdi = tx[63];
      tx = tx << 1;
      #400;
      spi_sck = 1'b1;
      rx = {rx[62:0], sdo_line};
      oe_seen = oe_seen | spi_sdo_oe;
      #400;
    end
    spi_sck = mode11;
    #400;
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #400;
  endtask
endmodule

// [verification/tb_afe_spi_register_port.sv]
/*
  Self-checking bench of the serial register port with a host model.
  Assumes the port, its package and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb_afe_spi_register_port;
  import afs_pkg::*;
  // ----------------------------------------------------------------
  // Signals, instances, clock
  // ----------------------------------------------------------------
  logic ref_clk, rstn, hw_reset_n, ch_data_new;
  logic cs_n, sck, sdi, sdo, sdo_oe, rdy_n, rdy_oe;
  logic [23:0] ch0, ch1, c0, c1;
  logic [47:0] e48;
  logic [31:0] e32;
  logic [63:0] r;
  logic [7:0] a, b, stat;
  afs_state_t lst;
  integer seed = 32'h50628328;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  afs_spi_port i_dut (.ref_clk(ref_clk), .rstn(rstn), .hw_reset_n(hw_reset_n),
    .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .conv_ready_pulse_n(rdy_n), .conv_ready_pulse_n_oe(rdy_oe), .ch0_data(ch0),
    .ch1_data(ch1), .ch_data_new(ch_data_new), .link_state(lst));
  afs_host_model i_host (.spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(sdo_oe));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      results();
    end
  end

  // Compare helpers
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Bus helpers: read n bytes from chip 0, write n bytes after a command
  task automatic rd(input logic m, input int n, input logic [4:0] ad);
    i_host.frame(m, n + 1, {2'h0, ad, 1'b1, 56'h0}, r);
  endtask
  task automatic wr(input int n, input logic [7:0] cmd, input logic [55:0] d);
    i_host.frame(1'b0, n + 1, {cmd, d}, r);
    chk1("sdo_oe_in_write", 1'b0, i_host.oe_seen);
  endtask

  // Second byte read from 0x1a for each loop mode
  function automatic logic [7:0] loop_next(input logic [1:0] m);
    case (m)
      2'h2: return b;
      2'h3: return c0[23:16];
      default: return a;
    endcase
  endfunction

  task automatic results();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hw_reset_n = 1'b1;
    ch_data_new = 1'b0;
    ch0 = '0;
    ch1 = '0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(1'b0, 1, 5'h0c);
    chk8("stat_default", 8'hb8, r[7:0]);
    chk1("own_chip_oe", 1'b1, i_host.oe_seen);
    a = $random(seed);
    b = $random(seed);
    wr(2, 8'h34, {a, b, 40'h0});
    rd(1'b0, 2, 5'h1a);
    chk8("wrap_first", a, r[15:8]);
    chk8("wrap_second", b, r[7:0]);
    rd(1'b0, 2, 5'h1f);
    chk8("undef_read", 8'h00, r[15:8] | r[7:0]);
    wr(2, 8'h3e, {~a, ~b, 40'h0});
    // New channel data and its ready pulse
    @(posedge ref_clk);
    c0 = $random(seed);
    c1 = $random(seed);
    ch0 <= c0;
    ch1 <= c1;
    ch_data_new <= 1'b1;
    @(posedge ref_clk);
    ch_data_new <= 1'b0;
    #1 chk1("ready_low", 1'b0, rdy_n);
    chk1("ready_oe", 1'b1, rdy_oe);
    @(posedge ref_clk);
    #1 chk1("ready_high", 1'b1, rdy_n);
    wr(1, 8'h00, {~c0[23:16], 48'h0});
    rd(1'b0, 6, 5'h00);
    e48 = {c0, c1};
    for (int i = 0; i < 6; i++) begin
      chk8("ch_bytes", e48[47 - 8 * i -: 8], r[47 - 8 * i -: 8]);
    end
    // Every loop mode, odd ones read in clock-idle-high mode
    for (int m = 0; m < 4; m++) begin
      stat = {m[1:0], 6'h24};
      wr(1, 8'h18, {stat, 48'h0});
      rd(m[0], 2, 5'h1a);
      chk8("loop_next", loop_next(m[1:0]), r[7:0]);
    end
    wr(1, 8'h18, {8'h84, 48'h0});
    wr(2, 8'h0e, {a, b, 40'h0});
    rd(1'b0, 1, 5'h07);
    chk8("no_increment", b, r[7:0]);
    rd(1'b0, 4, 5'h01);
    e32 = {c0[15:8], c1[23:16], c1[15:8], c0[23:16]};
    for (int i = 0; i < 4; i++) begin
      chk8("skip_low_byte", e32[31 - 8 * i -: 8], r[31 - 8 * i -: 8]);
    end
    // Channel 1 narrow, channel 0 wide: only address 5 is skipped
    wr(1, 8'h18, {8'h8c, 48'h0});
    rd(1'b0, 6, 5'h00);
    e48 = {c0, c1[23:8], c0[23:16]};
    for (int i = 0; i < 6; i++) begin
      chk8("ch1_16_bytes", e48[47 - 8 * i -: 8], r[47 - 8 * i -: 8]);
    end
    i_host.frame(1'b0, 2, {8'h59, 56'h0}, r);
    chk1("foreign_chip_oe", 1'b0, i_host.oe_seen);
    chk8("link_state", 8'(AFS_ST_IDLE), 8'(lst));
    // Hardware reset pin
    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 chk1("rst_ready_oe", 1'b0, rdy_oe);
    chk1("rst_sdo_oe", 1'b0, sdo_oe);
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(1'b0, 1, 5'h0c);
    chk8("stat_after_pin", 8'hb8, r[7:0]);
    rd(1'b0, 1, 5'h1a);
    chk8("cfg_after_pin", 8'h00, r[7:0]);
    results();
  end
endmodule
